// ===== inc/lie_bus_if.sv
// Parallel host port between the host and the LCD instruction executor.
`timescale 1ns/1ps
interface lie_bus_if;
	logic rs;
	logic rw;
	logic e;
	logic [7:0] db_h;
	logic db_h_oe;
	logic [7:0] db_d;
	logic db_d_oe;
	modport device (input rs, input rw, input e, input db_h, output db_d, output db_d_oe);
	modport host (output rs, output rw, output e, output db_h, output db_h_oe, input db_d);
endinterface : lie_bus_if

// ===== inc/lie_defines.svh
// Constant definitions shared by both ends of the LCD instruction executor.
`ifndef LIE_DEFINES_SVH
`define LIE_DEFINES_SVH
`define LIE_CMD_CLEAR 8'h01
`define LIE_CLEAR_MASK 8'hFF
`define LIE_HOME_MASK 8'hFE
`define LIE_HOME_CODE 8'h02
`define LIE_ENTRY_MASK 8'hFC
`define LIE_ENTRY_CODE 8'h04
`define LIE_SEGORD_MASK 8'hFE
`define LIE_SEGORD_CODE 8'h06
`define LIE_FSET_MASK 8'hE0
`define LIE_FSET_CODE 8'h20
`define LIE_SHEN_MASK 8'hF0
`define LIE_SHEN_CODE 8'h10
`define LIE_BIT_RE 2
`define LIE_BIT_DC 1
`define LIE_BIT_ID 1
`define LIE_BIT_S 0
`define LIE_BIT_BUSY 7
`define LIE_SPACE 8'h20
`define LIE_AC_ZERO 7'h00
`define LIE_TEXT_DEPTH 80
`define LIE_TEXT_LAST 7'h4F
`define LIE_CYC_CLEAR 8'hA0
`define LIE_CYC_HOME 8'h50
`define LIE_CYC_SHORT 8'h04
`define LIE_CYC_DATA 8'h04
`endif

// ===== inc/lie_pkg.sv
// Types shared by both ends of the LCD instruction executor.
package lie_pkg;
	typedef logic [7:0] lie_byte_t;
	typedef logic [6:0] lie_addr_t;
endpackage : lie_pkg

// ===== rtl/lie_device.sv
// Device end: latches host transfers and executes the instruction subset.
// Summary of operation
// R1 - Latch transfers, decode by select, direction, data
// R2 - Status read shows busy on bit seven
// R3 - Host polls busy low before next instruction
// R4 - Host waits half period after busy drop
// R5 - Step address counter after each RAM access
// R6 - Clear fills text RAM with spaces, zeroes address
// R7 - Clear homes cursor and forces increment
// R8 - Return home zeroes address, undoes shift
// R9 - Power-down grounds all common and segment outputs
// R10 - Power-down switches off drive voltage converter
// R11 - Power-down bit low leaves power-down
// R12 - Direction high increments address, cursor right
// R13 - Direction low decrements address, cursor left
// R14 - Glyph and icon RAM follow same direction
// R15 - Shift bit shifts enabled lines on text writes
// R16 - No shift otherwise: reads, glyph, icon RAM
// R17 - Order bit low gives normal segment order
// R18 - Order bit high gives reversed segment order
// R19 - Host sets bit one in extended entry mode
// R20 - Host sets order bit with function set; the device takes it from the extended entry-mode code instead
// R21 - Extended select picks basic or extended decode
// R22 - Per-line enables select which lines shift
// R23 - Each instruction holds busy a fixed time
`timescale 1ns/1ps
`include "lie_defines.svh"
module lie_device
	import lie_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Host port
	lie_bus_if.device bus,
	// Display state seen by the drive logic
	output logic [6:0] ram_address_counter_o,
	output logic [7:0] line_shift_o,
	output logic [3:0] line_shift_enable_o,
	output logic shift_left_pulse_o,
	output logic shift_right_pulse_o,
	output logic power_down_bit_o,
	output logic converter_on_o,
	output logic drive_ground_o,
	output logic segment_order_bit_o,
	output logic busy_o,
	// Text RAM write port, used here only by clear
	output logic text_we_o,
	output logic [6:0] text_addr_o,
	output logic [7:0] text_data_o
);
	logic [2:0] e_sync;
	logic rs_s1, rs_s2, rw_s1, rw_s2;
	lie_byte_t db_s1, db_s2;
	logic strobe;
	lie_byte_t instruction_latch;
	lie_byte_t data_latch;
	logic extended_set_select;
	logic shift_sel_dc;
	logic entry_increment;
	logic entry_shift;
	logic [7:0] busy_cnt;
	logic [7:0] next_busy_cnt;
	logic clearing;
	lie_addr_t clear_addr;
	lie_byte_t next_rd;

	// Host pins cross into this clock through two flops; the strobe is sampled falling.
	always_ff @(posedge mclk_i) begin
		e_sync <= {e_sync[1:0], bus.e};
		rs_s1 <= bus.rs;
		rs_s2 <= rs_s1;
		rw_s1 <= bus.rw;
		rw_s2 <= rw_s1;
		db_s1 <= bus.db_h;
		db_s2 <= db_s1;
	end
	assign strobe = resetn_i && e_sync[2] && !e_sync[1];

	wire wr_inst = strobe && !rs_s2 && !rw_s2 && !busy_o;
	wire wr_data = strobe && rs_s2 && !rw_s2 && !busy_o;
	wire rd_data = strobe && rs_s2 && rw_s2 && !busy_o;
	wire is_clear = (db_s2 & `LIE_CLEAR_MASK) == `LIE_CMD_CLEAR;
	wire is_home = (db_s2 & `LIE_HOME_MASK) == `LIE_HOME_CODE;
	wire is_entry = (db_s2 & `LIE_ENTRY_MASK) == `LIE_ENTRY_CODE;
	wire is_segord = (db_s2 & `LIE_SEGORD_MASK) == `LIE_SEGORD_CODE;
	wire is_fset = (db_s2 & `LIE_FSET_MASK) == `LIE_FSET_CODE;
	wire is_shen = (db_s2 & `LIE_SHEN_MASK) == `LIE_SHEN_CODE;

	// Latches for instructions and data.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			instruction_latch <= 8'h00;
			data_latch <= 8'h00;
		end else begin
			if (wr_inst) begin
				instruction_latch <= db_s2; // R1
			end
			if (wr_data) begin
				data_latch <= db_s2; // R1
			end
		end
	end

	// Mode bits written by instructions.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			extended_set_select <= 1'b0;
			shift_sel_dc <= 1'b0;
			entry_increment <= 1'b1;
			entry_shift <= 1'b0;
			power_down_bit_o <= 1'b0;
			segment_order_bit_o <= 1'b0;
			line_shift_enable_o <= 4'h0;
		end else if (wr_inst) begin
			if (is_fset) begin
				extended_set_select <= db_s2[`LIE_BIT_RE]; // R21
				if (!db_s2[`LIE_BIT_RE]) begin
					shift_sel_dc <= db_s2[`LIE_BIT_DC];
				end
			end else if (is_clear) begin
				entry_increment <= 1'b1; // R7
			end else if (is_home && extended_set_select) begin
				power_down_bit_o <= db_s2[0]; // R9 R11
			end else if (is_segord && extended_set_select) begin
				segment_order_bit_o <= db_s2[0]; // R17 R18
			end else if (is_entry && !extended_set_select) begin
				entry_increment <= db_s2[`LIE_BIT_ID]; // R12 R13
				entry_shift <= db_s2[`LIE_BIT_S];
			end else if (is_shen && shift_sel_dc && !extended_set_select) begin
				line_shift_enable_o <= db_s2[3:0]; // R22
			end
		end
	end

	// Address counter: set by clear and home, stepped after every RAM access.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ram_address_counter_o <= `LIE_AC_ZERO;
		end else if (wr_inst && (is_clear || (is_home && !extended_set_select))) begin
			ram_address_counter_o <= `LIE_AC_ZERO; // R6 R8
		end else if (wr_data || rd_data) begin
			if (entry_increment) begin
				ram_address_counter_o <= ram_address_counter_o + 7'h01; // R5 R12 R14
			end else begin
				ram_address_counter_o <= ram_address_counter_o - 7'h01; // R5 R13 R14
			end
		end
	end

	// Per-line display shift offsets; each enabled line moves individually.
	wire shift_now = wr_data && entry_shift; // R15 R16
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_line
			always_ff @(posedge mclk_i) begin
				if (!resetn_i) begin
					line_shift_o[2*gi+1:2*gi] <= 2'b00;
				end else if (wr_inst && (is_clear || (is_home && !extended_set_select))) begin
					line_shift_o[2*gi+1:2*gi] <= 2'b00; // R8
				end else if (shift_now && line_shift_enable_o[gi]) begin
					if (entry_increment) begin
						line_shift_o[2*gi+1:2*gi] <= line_shift_o[2*gi+1:2*gi] - 2'b01; // R15 R22
					end else begin
						line_shift_o[2*gi+1:2*gi] <= line_shift_o[2*gi+1:2*gi] + 2'b01; // R15 R22
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			shift_left_pulse_o <= 1'b0;
			shift_right_pulse_o <= 1'b0;
		end else begin
			shift_left_pulse_o <= shift_now && entry_increment; // R15
			shift_right_pulse_o <= shift_now && !entry_increment; // R15
		end
	end

	// Power-down drives: outputs to ground and converter off.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			converter_on_o <= 1'b1;
			drive_ground_o <= 1'b0;
		end else begin
			converter_on_o <= !power_down_bit_o; // R10
			drive_ground_o <= power_down_bit_o; // R9
		end
	end

	// Clear sweep writes a space to every text location, one per cycle.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			clearing <= 1'b0;
			clear_addr <= `LIE_AC_ZERO;
			text_we_o <= 1'b0;
			text_addr_o <= `LIE_AC_ZERO;
			text_data_o <= 8'h00;
		end else begin
			text_we_o <= clearing;
			text_addr_o <= clear_addr;
			text_data_o <= `LIE_SPACE; // R6
			if (wr_inst && is_clear) begin
				clearing <= 1'b1;
				clear_addr <= `LIE_AC_ZERO;
			end else if (clearing) begin
				clear_addr <= clear_addr + 7'h01;
				if (clear_addr == `LIE_TEXT_LAST) begin
					clearing <= 1'b0;
				end
			end
		end
	end

	// Busy counter; the clear time covers the whole sweep.
	// The flag is registered from the next count, so it tracks the counter cycle for cycle.
	always_comb begin
		next_busy_cnt = busy_cnt;
		if (wr_inst) begin
			if (is_clear) begin
				next_busy_cnt = `LIE_CYC_CLEAR; // R23
			end else if (is_home && !extended_set_select) begin
				next_busy_cnt = `LIE_CYC_HOME; // R23
			end else begin
				next_busy_cnt = `LIE_CYC_SHORT; // R23
			end
		end else if (wr_data || rd_data) begin
			next_busy_cnt = `LIE_CYC_DATA; // R23
		end else if (busy_cnt != 8'h00) begin
			next_busy_cnt = busy_cnt - 8'h01;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			busy_cnt <= 8'h00;
			busy_o <= 1'b0;
		end else begin
			busy_cnt <= next_busy_cnt;
			busy_o <= (next_busy_cnt != 8'h00);
		end
	end

	// Status read returns busy and the address counter; data reads return the data latch.
	always_comb begin
		next_rd = data_latch;
		if (!rs_s2) begin
			next_rd = {busy_o, ram_address_counter_o}; // R2
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			bus.db_d <= 8'h00;
			bus.db_d_oe <= 1'b0;
		end else begin
			bus.db_d <= next_rd;
			bus.db_d_oe <= rw_s2 && e_sync[1];
		end
	end
endmodule : lie_device

// ===== rtl/lie_host.sv
// Host end: issues instructions, polling busy before each one.
`timescale 1ns/1ps
`include "lie_defines.svh"
module lie_host
	import lie_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// User request
	input wire logic req_i,
	input wire logic req_rs_i,
	input wire logic [7:0] req_data_i,
	output logic ready_o,
	output logic done_o,
	// Host port
	lie_bus_if.host bus
);
	typedef enum logic [2:0] {LIH_IDLE, LIH_POLL_HI, LIH_POLL_LO, LIH_GAP, LIH_WR_HI,
		LIH_WR_LO} lie_hstate_e;
	lie_hstate_e state;
	logic [3:0] cnt;
	logic rs_q;
	lie_byte_t data_q;
	logic [1:0] busy_sync;

	always_ff @(posedge mclk_i) begin
		busy_sync <= {busy_sync[0], bus.db_d[`LIE_BIT_BUSY]};
	end

	// Each phase of the strobe lasts eight clocks so the device sees it after its synchroniser.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state <= LIH_IDLE;
			cnt <= 4'h0;
			rs_q <= 1'b0;
			data_q <= 8'h00;
			bus.rs <= 1'b0;
			bus.rw <= 1'b1;
			bus.e <= 1'b0;
			bus.db_h <= 8'h00;
			bus.db_h_oe <= 1'b0;
			ready_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			cnt <= cnt + 4'h1;
			case (state)
				LIH_IDLE: begin
					ready_o <= 1'b1;
					if (req_i) begin
						rs_q <= req_rs_i;
						data_q <= req_data_i;
						ready_o <= 1'b0;
						bus.rs <= 1'b0;
						bus.rw <= 1'b1;
						bus.e <= 1'b1;
						cnt <= 4'h0;
						state <= LIH_POLL_HI;
					end
				end
				LIH_POLL_HI: begin
					if (cnt == 4'h7) begin
						bus.e <= 1'b0;
						cnt <= 4'h0;
						state <= LIH_POLL_LO;
					end
				end
				LIH_POLL_LO: begin
					if (cnt == 4'h7) begin
						cnt <= 4'h0;
						if (busy_sync[1]) begin
							bus.e <= 1'b1; // R3
							state <= LIH_POLL_HI;
						end else begin
							state <= LIH_GAP; // R3
						end
					end
				end
				LIH_GAP: begin
					if (cnt == 4'h3) begin
						bus.rs <= rs_q; // R4
						bus.rw <= 1'b0;
						bus.db_h <= data_q;
						bus.db_h_oe <= 1'b1;
						bus.e <= 1'b1;
						cnt <= 4'h0;
						state <= LIH_WR_HI;
					end
				end
				LIH_WR_HI: begin
					if (cnt == 4'h7) begin
						bus.e <= 1'b0;
						cnt <= 4'h0;
						state <= LIH_WR_LO;
					end
				end
				LIH_WR_LO: begin
					if (cnt == 4'h7) begin
						bus.db_h_oe <= 1'b0;
						bus.rw <= 1'b1;
						done_o <= 1'b1;
						state <= LIH_IDLE;
					end
				end
				default: begin
					state <= LIH_IDLE;
				end
			endcase
		end
	end
endmodule : lie_host

// ===== verif/lcd_instruction_executor_tb.sv
// Bench: host and device joined, compared with an integer model.
`timescale 1ns/1ps
module lcd_instruction_executor_tb;
	import lie_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic req_i = 1'b0;
	logic req_rs_i = 1'b0;
	lie_byte_t req_data_i = 8'h00;
	logic ready_o, done_o, busy_o, power_down_bit_o, converter_on_o, drive_ground_o;
	logic segment_order_bit_o, shift_left_pulse_o, shift_right_pulse_o, text_we_o, bprev;
	logic [6:0] ram_address_counter_o, text_addr_o;
	logic [7:0] line_shift_o, text_data_o;
	int ac = 0, inc = 1, sh = 0, re = 0, pd = 0, ord = 0, nlp = 0, nrp = 0, i;
	int blen = 0, lp = 0, rp = 0, wcnt = 0, bad_count = 0, total_checks = 0;
	bit quick = 1'b0;
	int seed = 24532;
	lie_bus_if bus_if();
	lie_host u_lie_host (.mclk_i, .resetn_i, .req_i, .req_rs_i, .req_data_i, .ready_o,
		.done_o, .bus(bus_if));
	lie_device u_lie_device (.mclk_i, .resetn_i, .bus(bus_if), .ram_address_counter_o,
		.line_shift_o, .line_shift_enable_o(), .shift_left_pulse_o, .shift_right_pulse_o,
		.power_down_bit_o, .converter_on_o, .drive_ground_o, .segment_order_bit_o, .busy_o,
		.text_we_o, .text_addr_o, .text_data_o);
	lie_chk u_lie_chk (.mclk_i, .resetn_i, .rs(bus_if.rs), .rw(bus_if.rw), .e(bus_if.e),
		.db_d(bus_if.db_d), .db_d_oe(bus_if.db_d_oe), .busy_o, .power_down_bit_o,
		.converter_on_o, .drive_ground_o, .shift_left_pulse_o, .shift_right_pulse_o,
		.text_we_o, .text_addr_o, .text_data_o);
	always #50 mclk_i = ~mclk_i;
	// Busy length is measured per run so every instruction's duration is seen.
	always @(posedge mclk_i) begin
		if (busy_o === 1'b1) blen <= bprev ? blen + 1 : 1;
		bprev <= busy_o;
		lp <= lp + (shift_left_pulse_o === 1'b1);
		rp <= rp + (shift_right_pulse_o === 1'b1);
		wcnt <= wcnt + (text_we_o === 1'b1);
	end
	task automatic chk(string nm, logic [7:0] s, logic [7:0] x);
		total_checks++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected %s: expected %0h, seen %0h", nm, x, s);
		end
	endtask : chk
	task automatic state;
		chk("address", {1'b0, ram_address_counter_o}, ac[7:0]);
		chk("power down", {7'h00, power_down_bit_o}, pd[7:0]);
		chk("converter", {7'h00, converter_on_o}, 8'(!pd));
		chk("ground", {7'h00, drive_ground_o}, pd[7:0]);
		chk("order", {7'h00, segment_order_bit_o}, ord[7:0]);
		chk("left shifts", lp[7:0], nlp[7:0]);
		chk("right shifts", rp[7:0], nrp[7:0]);
	endtask : state
	task automatic send(input logic r, input lie_byte_t d);
		int n;
		int eb;
		n = 0;
		while (ready_o !== 1'b1 && n < 1000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (n >= 1000) bad_count++;
		req_i = 1'b1;
		req_rs_i = r;
		req_data_i = d;
		@(posedge mclk_i);
		#1;
		req_i = 1'b0;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (done_o !== 1'b1 && n < 3000);
		if (n >= 3000) bad_count++;
		n = 0;
		while (!quick && busy_o !== 1'b0 && n < 300) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (n >= 300) bad_count++;
		eb = 4;
		if (r) begin
			ac = inc ? ac + 1 : ac - 1;
			if (sh && inc) nlp++;
			if (sh && !inc) nrp++;
		end else if (d == 8'h01) begin
			ac = 0;
			inc = 1;
			eb = 160;
		end else if (d[7:1] == 7'h01 && re) pd = d[0];
		else if (d[7:1] == 7'h01) begin
			ac = 0;
			eb = 80;
			chk("line shift", line_shift_o, 8'h00);
		end else if (d[7:2] == 6'h01 && !re) begin
			inc = d[1];
			sh = d[0];
		end else if (d[7:1] == 7'h03 && re) ord = d[0];
		else if (d[7:5] == 3'h1) re = d[2];
		ac = ac & 127;
		if (!quick) chk("busy cycles", blen[7:0], eb[7:0]);
		state();
	endtask : send
	task automatic close_out;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	initial begin
		#1_000_000;
		bad_count++;
		close_out();
	end
	initial begin
		static logic [8:0] seq [16] = '{9'h034, 9'h003, 9'h002, 9'h007, 9'h006, 9'h007, 9'h032,
			9'h01F, 9'h007, 9'h1A5, 9'h13C, 9'h005, 9'h1FF, 9'h004, 9'h100, 9'h002};
		lie_byte_t d;
		int w0;
		repeat (5) @(posedge mclk_i);
		#1 resetn_i = 1'b1;
		@(posedge mclk_i);
		#1;
		state();
		// A set order bit must survive the entry-mode code that shares its encoding.
		foreach (seq[k]) send(seq[k][8], seq[k][7:0]);
		w0 = wcnt;
		send(1'b0, 8'h01);
		chk("clear writes", 8'(wcnt - w0), 8'h50);
		// A second clear is left busy, so the next request polls a busy status.
		quick = 1'b1;
		send(1'b0, 8'h01);
		quick = 1'b0;
		send(1'b1, 8'h41);
		for (i = 0; i < 15; i++) begin
			d = 8'h04 | 8'($random(seed) & 3);
			if (ac < 3) d[1] = 1'b1;
			send(1'b0, d);
			repeat (3) begin
				d = 8'($random(seed));
				send(1'b1, d);
			end
		end
		close_out();
	end
endmodule : lcd_instruction_executor_tb

// ===== verif/lie_chk.sv
// Checker on the host port and the device status outputs.
`timescale 1ns/1ps
module lie_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Host port
	input wire logic rs,
	input wire logic rw,
	input wire logic e,
	input wire logic [7:0] db_d,
	input wire logic db_d_oe,
	// Device status
	input wire logic busy_o,
	input wire logic power_down_bit_o,
	input wire logic converter_on_o,
	input wire logic drive_ground_o,
	input wire logic shift_left_pulse_o,
	input wire logic shift_right_pulse_o,
	input wire logic text_we_o,
	input wire logic [6:0] text_addr_o,
	input wire logic [7:0] text_data_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	sequence strobe_start;
		$rose(e);
	endsequence
	sequence write_strobe;
		$fell(e) ##0 !rw;
	endsequence
	sequence busy_status_read;
		busy_o [*4] ##0 (db_d_oe && !rs && rw);
	endsequence
	chk_strobe_width: assert property (strobe_start |-> e [*8] ##1 !e)
		else $error("strobe width wrong");
	chk_busy_after_write: assert property (write_strobe |-> ##[1:6] busy_o)
		else $error("busy not raised after write");
	chk_status_busy_bit: assert property (busy_status_read |-> db_d[7])
		else $error("status read hides busy");
	chk_write_when_idle: assert property (strobe_start ##0 !rw |-> !busy_o)
		else $error("write while busy");
	chk_pd_ground: assert property (power_down_bit_o && $past(power_down_bit_o)
		|-> drive_ground_o && !converter_on_o)
		else $error("power-down outputs not grounded");
	chk_pd_leave: assert property (!power_down_bit_o && $past(!power_down_bit_o)
		|-> converter_on_o && !drive_ground_o)
		else $error("power-down not left");
	chk_clear_space: assert property (text_we_o |-> text_data_o == 8'h20 && text_addr_o <= 7'h4F)
		else $error("clear write wrong");
	chk_shift_single: assert property (shift_left_pulse_o || shift_right_pulse_o
		|=> !shift_left_pulse_o && !shift_right_pulse_o)
		else $error("shift pulse too long");
	chk_shift_excl: assert property (!(shift_left_pulse_o && shift_right_pulse_o))
		else $error("both shift directions");
endmodule : lie_chk
